/* logic/dtsc_cfg.svh */
// constants for the debug test port and its scan chains
`ifndef DTSC_CFG_SVH
`define DTSC_CFG_SVH
// instruction codes
`define DTSC_IR_SCAN_SEL    4'h2
`define DTSC_IR_INTEST      4'hc
`define DTSC_IR_IDCODE      4'he
`define DTSC_IR_BYPASS      4'hf
`define DTSC_IR_RESTART     4'h4
`define DTSC_IR_CAPTURE     4'h1
// chain selector
`define DTSC_SEL_CAPTURE    4'h8
`define DTSC_CH_USER        4'h0
`define DTSC_CH_CORE        4'h1
`define DTSC_CH_BPU         4'h2
`define DTSC_CH_SYSCP       4'hf
// identity values, arbitrary
`define DTSC_ID_CODE        32'h1234_5671
`define DTSC_SYSCP_ID       32'h0000_a5a1
// comms channel
`define DTSC_COMMS_VER      4'h1
`define DTSC_BPA_CTRL       5'h04
`define DTSC_BPA_DATA       5'h05
// system coprocessor operations
`define DTSC_OP_ID          4'h0
`define DTSC_OP_LAST_RW     4'h7
`define DTSC_OP_INV_CACHE   4'h8
`define DTSC_OP_INV_TLB     4'h9
`define DTSC_OP_INV_ENTRY   4'ha
// apb byte addresses
`define DTSC_APB_CTRL       12'h000
`define DTSC_APB_DATA       12'h004
`define DTSC_APB_STAT       12'h008
`define DTSC_APB_COP_BASE   12'h020
`define DTSC_APB_BP_BASE    12'h080
`endif

/* logic/dtsc_pkg.sv */
// types for the debug test port
package dtsc_pkg;
	// sixteen controller states
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} dtsc_tap_state_type;
	// whole state of the block
	typedef struct packed {
		logic [3:0]          sync1;
		logic [3:0]          sync2;
		dtsc_tap_state_type  tap;
		logic [3:0]          ir_shift;
		logic [3:0]          ir_cur;
		logic [3:0]          sel_shift;
		logic [3:0]          chain;
		logic                bypass;
		logic [31:0]         id_shift;
		logic [32:0]         c1;
		logic [37:0]         c2;
		logic [36:0]         c15;
		logic [3:0]          c15_op;
		logic [31:0]         core_out;
		logic                brk_out;
		logic [7:1][31:0]    cop;
		logic [31:0][31:0]   bp;
		logic [31:0]         hts_data;
		logic                hts_full;
		logic [1:0]          full_sync;
		logic                tdo;
		logic [31:0]         prdata;
		logic                slverr;
		logic                restart;
		logic [2:0]          inval;
	} dtsc_state_type;
endpackage

/* logic/dtsc_tap.sv */
// debug test port: controller, instructions, scan chains, comms channel
//
// Contract
// - serial data write sets full flag
// - processor data read clears full flag
// - core chain 33 cells, break out first
// - coprocessor chain 37 cells, data0 first
// - operation codes select coprocessor registers
// - coprocessor operations act only in update
// - operation field captures as zero
// - user chain 0 external, signals exported
// - test reset: system mode, IDCODE current
// - decode scan select, INTEST, IDCODE, BYPASS, restart
// - sample pins only when clock enable high; test reset here acts whether the enable is high or not
// - selector captures 1000, shifts chain number
// - update selects chain, chain 0 after reset
// - selector register is four bits
// - INTEST puts chain in test mode, captures
// - INTEST shifts captured out, new in
// - ID register captures, shifts, holds in update
// - bypass captures zero, one-cycle delay
// - bypass leaves scan cells in system mode
// - undefined codes act as bypass
// - restart acts as bypass, restarts on idle
// - instruction register captures 0001, LSB first
// - breakpoint chain 38 bits, bit 37 write
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "dtsc_cfg.svh"

module dtsc_tap (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// serial test pins
	input  wire logic         test_serial_in,
	input  wire logic         test_mode_select,
	input  wire logic         test_clock_enable,
	input  wire logic         test_reset_n,
	output logic              test_serial_out,
	// core side
	input  wire logic [31:0]  core_data_in,
	input  wire logic         break_request_in,
	output logic [31:0]       core_data_out,
	output logic              break_out,
	output logic              scan_test_mode,
	output logic              restart_pulse,
	output logic              inval_cache,
	output logic              inval_tlb,
	output logic              inval_tlb_entry,
	// external user chain 0
	output logic              user_chain_select,
	output logic              user_capture,
	output logic              user_shift,
	output logic              user_update,
	output logic              user_serial_in,
	input  wire logic         user_serial_out,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr
);
	import dtsc_pkg::*;

	dtsc_state_type st;        // registered state
	dtsc_state_type next_st;   // next state

	// synchronised pins
	logic        tick;          // enabled test clock edge
	logic        tdi;           // synced serial in
	logic        tms;           // synced mode select
	logic        trst;          // synced test reset, active high
	// instruction decode
	logic        is_sel;        // chain select current
	logic        is_int;        // intest current
	logic        is_id;         // idcode current
	// apb decode
	logic        setup;         // apb setup phase
	logic        access;        // apb access phase
	logic        cop_hit;       // coprocessor window
	logic        bp_hit;        // breakpoint window
	logic [31:0] proc_ctrl;     // control word, processor view
	logic [31:0] dbg_ctrl;      // control word, debugger view
	logic [31:0] cop_rd;        // coprocessor read value

	// reset value of the state
	localparam dtsc_state_type ST_RESET = '{
		ir_cur: `DTSC_IR_IDCODE,
		tap: TLR,
		default: '0
	};

	// controller transitions
	function automatic dtsc_tap_state_type tap_next(
		input dtsc_tap_state_type s,
		input logic               m
	);
		case (s)
			TLR:     tap_next = m ? TLR : RTI;
			RTI:     tap_next = m ? SEL_DR : RTI;
			SEL_DR:  tap_next = m ? SEL_IR : CAP_DR;
			CAP_DR:  tap_next = m ? EX1_DR : SH_DR;
			SH_DR:   tap_next = m ? EX1_DR : SH_DR;
			EX1_DR:  tap_next = m ? UPD_DR : PAU_DR;
			PAU_DR:  tap_next = m ? EX2_DR : PAU_DR;
			EX2_DR:  tap_next = m ? UPD_DR : SH_DR;
			UPD_DR:  tap_next = m ? SEL_DR : RTI;
			SEL_IR:  tap_next = m ? TLR : CAP_IR;
			CAP_IR:  tap_next = m ? EX1_IR : SH_IR;
			SH_IR:   tap_next = m ? EX1_IR : SH_IR;
			EX1_IR:  tap_next = m ? UPD_IR : PAU_IR;
			PAU_IR:  tap_next = m ? EX2_IR : PAU_IR;
			EX2_IR:  tap_next = m ? UPD_IR : SH_IR;
			UPD_IR:  tap_next = m ? SEL_DR : RTI;
			default: tap_next = TLR;
		endcase
	endfunction

	// pin copies from the second sync stage
	// advance only on enabled edge
	assign tick = st.sync2[0];
	assign tdi  = st.sync2[1];
	assign tms  = st.sync2[2];
	assign trst = ~st.sync2[3];

	// instruction classes, everything else is bypass
	// public instruction decode
	assign is_sel = st.ir_cur == `DTSC_IR_SCAN_SEL;
	assign is_int = st.ir_cur == `DTSC_IR_INTEST;
	assign is_id  = st.ir_cur == `DTSC_IR_IDCODE;

	// apb address decode
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign cop_hit = paddr[11:5] == 7'(`DTSC_APB_COP_BASE >> 5);
	assign bp_hit  = paddr[11:7] == 5'(`DTSC_APB_BP_BASE >> 7);

	// control words for both sides
	// debugger reads the synced copy
	assign proc_ctrl = {`DTSC_COMMS_VER, 27'h0, st.hts_full};
	assign dbg_ctrl  = {`DTSC_COMMS_VER, 27'h0, st.full_sync[1]};

	// coprocessor read by last operation
	// operation selects the register
	always_comb begin
		cop_rd = 32'h0;
		if (st.c15_op == `DTSC_OP_ID) begin
			cop_rd = `DTSC_SYSCP_ID;
		end else if (st.c15_op <= `DTSC_OP_LAST_RW) begin
			cop_rd = st.cop[st.c15_op[2:0]];
		end
	end

	// next state of the whole block
	always_comb begin
		next_st = st;
		// two-flop synchronisers for the pins
		next_st.sync1 = {test_reset_n, test_mode_select,
			test_serial_in, test_clock_enable};
		next_st.sync2 = st.sync1;
		// debugger copy of full flag
		next_st.full_sync = {st.full_sync[0], st.hts_full};
		next_st.restart = 1'b0;
		next_st.inval = 3'h0;

		// apb setup: latch read data and error
		if (setup) begin
			next_st.slverr = 1'b0;
			next_st.prdata = 32'h0;
			if (paddr == `DTSC_APB_CTRL) begin
				next_st.prdata = proc_ctrl;
			end else if (paddr == `DTSC_APB_DATA) begin
				next_st.prdata = st.hts_data;
			end else if (paddr == `DTSC_APB_STAT) begin
				next_st.prdata = {23'h0, is_int, st.chain, st.ir_cur};
			end else if (cop_hit && paddr[1:0] == 2'h0) begin
				if (paddr[4:2] == 3'h0) begin
					next_st.prdata = `DTSC_SYSCP_ID;
				end else begin
					next_st.prdata = st.cop[paddr[4:2]];
				end
			end else if (bp_hit && paddr[1:0] == 2'h0) begin
				next_st.prdata = st.bp[paddr[6:2]];
			end else begin
				next_st.slverr = 1'b1;
			end
		end

		// apb access: writes and read side effects
		if (access) begin
			if (!pwrite && paddr == `DTSC_APB_DATA) begin
				next_st.hts_full = 1'b0;
			end
			if (pwrite && !st.slverr) begin
				if (cop_hit && paddr[4:2] != 3'h0) begin
					next_st.cop[paddr[4:2]] = pwdata;
				end else if (bp_hit) begin
					next_st.bp[paddr[6:2]] = pwdata;
				end
			end
		end

		// test logic, one step per enabled edge
		if (tick) begin
			next_st.tap = tap_next(st.tap, tms);
			case (st.tap)
				// reset state restores idcode
				TLR: begin
					next_st.ir_cur = `DTSC_IR_IDCODE;
				end
				CAP_IR: begin
					next_st.ir_shift = `DTSC_IR_CAPTURE;
				end
				SH_IR: begin
					next_st.ir_shift = {tdi, st.ir_shift[3:1]};
					next_st.tdo = st.ir_shift[0];
				end
				UPD_IR: begin
					next_st.ir_cur = st.ir_shift;
				end
				// data register capture
				CAP_DR: begin
					if (is_sel) begin
						next_st.sel_shift = `DTSC_SEL_CAPTURE;
					end else if (is_id) begin
						next_st.id_shift = `DTSC_ID_CODE;
					end else if (is_int) begin
						case (st.chain)
							`DTSC_CH_CORE: begin
								// data0 nearest input, break at output
								for (int i = 0; i < 32; i++) begin
									next_st.c1[32 - i] = core_data_in[i];
								end
								next_st.c1[0] = break_request_in;
							end
							`DTSC_CH_SYSCP: begin
								next_st.c15[35:32] = 4'h0;
								next_st.c15[31:0] = cop_rd;
							end
							default: begin
								// breakpoint chain captures nothing
							end
						endcase
					end else begin
						next_st.bypass = 1'b0;
					end
				end
				// data register shift
				SH_DR: begin
					if (is_sel) begin
						next_st.sel_shift = {tdi, st.sel_shift[3:1]};
						next_st.tdo = st.sel_shift[0];
					end else if (is_id) begin
						next_st.id_shift = {tdi, st.id_shift[31:1]};
						next_st.tdo = st.id_shift[0];
					end else if (is_int) begin
						case (st.chain)
							`DTSC_CH_USER: begin
								next_st.tdo = user_serial_out;
							end
							`DTSC_CH_CORE: begin
								next_st.c1 = {tdi, st.c1[32:1]};
								next_st.tdo = st.c1[0];
							end
							`DTSC_CH_BPU: begin
								next_st.c2 = {tdi, st.c2[37:1]};
								next_st.tdo = st.c2[0];
							end
							`DTSC_CH_SYSCP: begin
								// data0 in first and out first
								next_st.c15 = {tdi, st.c15[36:1]};
								next_st.tdo = st.c15[0];
							end
							default: begin
								// reserved chains scan out zero
								next_st.tdo = 1'b0;
							end
						endcase
					end else begin
						next_st.bypass = tdi;
						next_st.tdo = st.bypass;
					end
				end
				// data register update
				UPD_DR: begin
					if (is_sel) begin
						next_st.chain = st.sel_shift;
					end else if (is_int) begin
						case (st.chain)
							`DTSC_CH_CORE: begin
								// parallel outputs of the core chain
								next_st.core_out = {<<{st.c1[32:1]}};
								next_st.brk_out = st.c1[0];
							end
							`DTSC_CH_BPU: begin
								if (st.c2[37]) begin
									if (st.c2[36:32] == `DTSC_BPA_DATA) begin
										next_st.hts_data = st.c2[31:0];
									end else if (st.c2[36:32] != `DTSC_BPA_CTRL) begin
										next_st.bp[st.c2[36:32]] = st.c2[31:0];
									end
								end else if (st.c2[36:32] == `DTSC_BPA_CTRL) begin
									next_st.c2[31:0] = dbg_ctrl;
								end else if (st.c2[36:32] == `DTSC_BPA_DATA) begin
									next_st.c2[31:0] = 32'h0;
								end else begin
									next_st.c2[31:0] = st.bp[st.c2[36:32]];
								end
							end
							`DTSC_CH_SYSCP: begin
								next_st.c15_op = st.c15[35:32];
								if (st.c15[36]) begin
									if (st.c15[35:32] != `DTSC_OP_ID &&
										st.c15[35:32] <= `DTSC_OP_LAST_RW) begin
										next_st.cop[st.c15[34:32]] = st.c15[31:0];
									end
									next_st.inval = {
										st.c15[35:32] == `DTSC_OP_INV_ENTRY,
										st.c15[35:32] == `DTSC_OP_INV_TLB,
										st.c15[35:32] == `DTSC_OP_INV_CACHE};
								end
							end
							default: begin
								// user chain updates outside
							end
						endcase
					end
					// id and bypass hold in update
				end
				default: begin
					// other states hold the registers
				end
			endcase
			if (next_st.ir_cur == `DTSC_IR_RESTART && st.tap != RTI &&
				next_st.tap == RTI) begin
				next_st.restart = 1'b1;
			end
		end

		// serial write sets full, wins over clear
		if (tick && st.tap == UPD_DR && is_int &&
			st.chain == `DTSC_CH_BPU && st.c2[37] &&
			st.c2[36:32] == `DTSC_BPA_DATA) begin
			next_st.hts_full = 1'b1;
		end

		// test reset forces idcode and chain 0
		if (trst) begin
			next_st.tap = TLR;
			next_st.ir_cur = `DTSC_IR_IDCODE;
			next_st.chain = `DTSC_CH_USER;
			next_st.tdo = 1'b0;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// serial and core outputs
	assign test_serial_out = st.tdo;
	assign scan_test_mode  = is_int;
	assign core_data_out   = st.core_out;
	assign break_out       = st.brk_out;
	assign restart_pulse   = st.restart;
	assign inval_cache     = st.inval[0];
	assign inval_tlb       = st.inval[1];
	assign inval_tlb_entry = st.inval[2];

	// user chain control at the boundary
	assign user_chain_select = is_int && st.chain == `DTSC_CH_USER;
	assign user_capture = tick && user_chain_select && st.tap == CAP_DR;
	assign user_shift   = tick && user_chain_select && st.tap == SH_DR;
	assign user_update  = tick && user_chain_select && st.tap == UPD_DR;
	assign user_serial_in = tdi;

	// apb answers in the first access cycle
	assign pready  = access;
	assign prdata  = st.prdata;
	assign pslverr = access & st.slverr;

endmodule

/* tb/dtsc_tap_asserts.sv */
// checker for the debug test port
`timescale 1ns/10ps
module dtsc_tap_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// serial pins
	input wire logic        test_clock_enable,
	input wire logic        test_reset_n,
	input wire logic        test_serial_out,
	// core and user chain
	input wire logic        scan_test_mode,
	input wire logic        restart_pulse,
	input wire logic        inval_cache,
	input wire logic        inval_tlb,
	input wire logic        inval_tlb_entry,
	input wire logic        user_chain_select,
	input wire logic        user_capture,
	input wire logic        user_shift,
	input wire logic        user_update,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready
);
	logic [2:0] quiet; // cycles since enable pin high
	logic       clr;   // data word taken, link idle since
	logic       rd;    // apb read access
	logic       inv;   // any invalidate pulse
	assign rd = psel && penable && !pwrite;
	assign inv = inval_cache || inval_tlb || inval_tlb_entry;
	// count link silence, saturating
	always_ff @(posedge clk) begin
		if (!reset_n || test_clock_enable)
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	// remember a data read made while the link was quiet
	always_ff @(posedge clk) begin
		if (!reset_n || test_clock_enable)
			clr <= 1'b0;
		else if (rd && paddr == 12'h004 && quiet == 3'h7)
			clr <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pready_access: assert property (pready == (psel && penable)) else $error("pready wrong");
	a_read_clears: assert property (rd && paddr == 12'h000 && clr && $past(clr) |-> !prdata[0]) else $error("full kept");
	a_test_reset: assert property (!test_reset_n [*3] |=> !scan_test_mode && !user_chain_select) else $error("no reset");
	a_idle_hold: assert property ((!test_clock_enable && test_reset_n) [*6] |-> $stable(test_serial_out))
		else $error("step without enable");
	a_user_strobes: assert property (user_capture || user_shift || user_update |-> user_chain_select && quiet < 3'h4
		&& $onehot0({user_capture, user_shift, user_update})) else $error("bad user strobe");
	a_intest_step: assert property ($rose(scan_test_mode) |-> quiet < 3'h6) else $error("test mode without step");
	a_inval_pulse: assert property (inv |-> $onehot0({inval_cache, inval_tlb, inval_tlb_entry}) && quiet < 3'h6
		&& scan_test_mode) else $error("bad invalidate");
	a_restart_once: assert property (restart_pulse |-> (quiet < 3'h6 && !scan_test_mode) ##1 !restart_pulse)
		else $error("bad restart");
	cover property (restart_pulse);
	cover property (inval_tlb_entry);
	cover property ($rose(scan_test_mode));
	cover property (user_shift);
endmodule
bind dtsc_tap dtsc_tap_asserts dtsc_tap_asserts_inst (.clk, .reset_n, .test_clock_enable, .test_reset_n,
	.test_serial_out, .scan_test_mode, .restart_pulse, .inval_cache, .inval_tlb, .inval_tlb_entry,
	.user_chain_select, .user_capture, .user_shift, .user_update, .psel, .penable, .pwrite, .paddr, .prdata, .pready);

/* tb/dtsc_dbg_host.sv */
// debugger model driving the serial test pins
`timescale 1ns/10ps
module dtsc_dbg_host (
	// clock
	input wire logic clk,
	// serial pins
	output logic     test_serial_in,
	output logic     test_mode_select,
	output logic     test_clock_enable,
	output logic     test_reset_n,
	input wire logic test_serial_out
);
	// pins idle, test reset held
	initial begin
		test_serial_in = 1'b0;
		test_mode_select = 1'b1;
		test_clock_enable = 1'b0;
		test_reset_n = 1'b0;
	end
	// one enabled step, then the answer is read
	task step(input logic m, input logic d, output logic o);
		@(posedge clk);
		test_clock_enable <= 1'b1;
		test_mode_select <= m;
		test_serial_in <= d;
		@(posedge clk);
		test_clock_enable <= 1'b0;
		test_serial_in <= ~d;
		test_mode_select <= ~m;
		repeat (4) @(posedge clk);
		o = test_serial_out;
	endtask
	task link_reset();
		logic o;
		@(posedge clk);
		test_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		test_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		step(1'b0, 1'b0, o);
	endtask
	// scan n bits lsb first from idle back to idle
	task scan(input logic ir, input int n, input logic [37:0] di, output logic [37:0] q);
		logic o;
		q = 38'h0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, di[i], o);
			q[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the debug test port
`timescale 1ns/10ps
`include "dtsc_cfg.svh"
module tb;
	logic        clk, reset_n, psel, penable, pwrite, break_request_in, user_serial_out, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, core_data_in, core_data_out, prdata, r;
	logic        test_serial_in, test_mode_select, test_clock_enable, test_reset_n, test_serial_out;
	logic        break_out, scan_test_mode, restart_pulse, inval_cache, inval_tlb, inval_tlb_entry;
	logic        user_chain_select, user_capture, user_shift, user_update, user_serial_in, pready, pslverr;
	logic [37:0] d;
	logic [3:0]  ext;   // external user chain model
	int          err_count, num_checks, n_rst, n_inv, n_ucap, n_uupd;
	dtsc_tap dtsc_tap_inst (.clk, .reset_n, .test_serial_in, .test_mode_select, .test_clock_enable,
		.test_reset_n, .test_serial_out, .core_data_in, .break_request_in, .core_data_out, .break_out,
		.scan_test_mode, .restart_pulse, .inval_cache, .inval_tlb, .inval_tlb_entry, .user_chain_select,
		.user_capture, .user_shift, .user_update, .user_serial_in, .user_serial_out, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	dtsc_dbg_host host_inst (.clk, .test_serial_in, .test_mode_select, .test_clock_enable, .test_reset_n,
		.test_serial_out);
	assign user_serial_out = ext[0];
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// count pulses, weight each invalidate, model the external user chain
	always @(posedge clk) begin
		if (restart_pulse === 1'b1)
			n_rst++;
		if ((inval_cache | inval_tlb | inval_tlb_entry) === 1'b1)
			n_inv += {inval_tlb_entry, inval_tlb, inval_cache};
		if (user_capture === 1'b1)
			n_ucap++;
		if (user_update === 1'b1)
			n_uupd++;
		if (user_shift === 1'b1)
			ext <= {user_serial_in, ext[3:1]};
	end
	task close_out(input bit to);
		if (to)
			err_count++;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [37:0] seen, input logic [37:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			close_out(1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ir(input logic [3:0] c);
		host_inst.scan(1'b1, 4, {34'h0, c}, d);
		chk(d[3:0], 4'h1);
	endtask
	task sel(input logic [3:0] ch);
		ir(4'h2);
		host_inst.scan(1'b0, 4, {34'h0, ch}, d);
		chk(d[3:0], 4'h8);
		ir(4'hc);
	endtask
	task rd4();
		repeat (2) host_inst.scan(1'b0, 38, {1'b0, 5'h4, 32'h0}, d);
	endtask
	task t_idcode();
		host_inst.scan(1'b0, 32, 38'h0, d);
		chk(d[31:0], `DTSC_ID_CODE);
		apb(1'b0, 12'h008, 32'h0);
		chk(r[8:0], 9'h00e);
		$display("test idcode done");
	endtask
	task t_bypass();
		logic [3:0] c [4];
		c = '{4'hf, 4'h5, 4'h4, 4'h9};
		n_rst = 0;
		foreach (c[i]) begin
			ir(c[i]);
			host_inst.scan(1'b0, 8, 38'h5a, d);
			chk(d[7:0], 8'hb4);
		end
		chk(n_rst, 2);
		$display("test bypass done");
	endtask
	task t_user();
		ir(4'hc);
		chk(user_chain_select, 1'b1);
		chk(scan_test_mode, 1'b1);
		host_inst.scan(1'b0, 4, 38'h5, d);
		chk(d[3:0], 4'ha);
		host_inst.scan(1'b0, 4, 38'h0, d);
		chk(d[3:0], 4'h5);
		chk(n_ucap, 2);
		chk(n_uupd, 2);
		$display("test user chain done");
	endtask
	task t_chain1();
		logic [32:0] di;
		logic [31:0] x, y;
		di = 33'h0_f0f0_55ab;
		sel(4'h1);
		host_inst.scan(1'b0, 33, {5'h0, di}, d);
		for (int i = 0; i < 32; i++) begin
			x[i] = d[32 - i];
			y[i] = di[32 - i];
		end
		chk(d[0], break_request_in);
		chk(x, core_data_in);
		chk(core_data_out, y);
		chk(break_out, di[0]);
		$display("test chain1 done");
	endtask
	task t_cop();
		int base;
		sel(4'hf);
		for (int i = 1; i < 8; i++) begin
			host_inst.scan(1'b0, 37, {2'h1, i[3:0], 32'h5a5a_0000 + i}, d);
			apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
			chk(r, 32'h5a5a_0000 + i);
		end
		host_inst.scan(1'b0, 37, 38'h0, d);
		host_inst.scan(1'b0, 37, {2'h0, 4'h3, 32'h0}, d);
		chk(d[35:0], {4'h0, `DTSC_SYSCP_ID});
		host_inst.scan(1'b0, 37, 38'h0, d);
		chk(d[31:0], 32'h5a5a_0003);
		chk(d[35:32], 4'h0);
		base = n_inv;
		for (int i = 8; i < 11; i++)
			host_inst.scan(1'b0, 37, {2'h1, i[3:0], 32'h0}, d);
		host_inst.scan(1'b0, 37, {2'h0, 4'h8, 32'h0}, d);
		chk(n_inv, base + 7);
		$display("test coprocessor done");
	endtask
	task t_comms();
		sel(4'h2);
		for (int i = 0; i < 4 && (i == 0 || d[0] !== 1'b0); i++)
			rd4();
		chk(d[0], 1'b0);
		host_inst.scan(1'b0, 38, {1'b1, 5'h5, 32'hdead_beef}, d);
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h1000_0001);
		rd4();
		chk(d[0], 1'b1);
		repeat (4) @(posedge clk);
		apb(1'b0, 12'h004, 32'h0);
		chk(r, 32'hdead_beef);
		apb(1'b0, 12'h000, 32'h0);
		chk(r[0], 1'b0);
		rd4();
		chk(d[0], 1'b0);
		host_inst.scan(1'b0, 38, {1'b1, 5'h3, 32'h600d_f00d}, d);
		host_inst.scan(1'b0, 38, {1'b0, 5'h3, 32'h0}, d);
		apb(1'b0, 12'h08c, 32'h0);
		chk(r, 32'h600d_f00d);
		apb(1'b1, 12'h098, 32'h1357_9bdf);
		chk(e, 1'b0);
		host_inst.scan(1'b0, 38, {1'b0, 5'h6, 32'h0}, d);
		host_inst.scan(1'b0, 38, 38'h0, d);
		chk(d[31:0], 32'h1357_9bdf);
		apb(1'b0, 12'h300, 32'h0);
		chk(e, 1'b1);
		apb(1'b0, 12'h082, 32'h0);
		chk(e, 1'b1);
		$display("test comms done");
	endtask
	task t_reset();
		host_inst.link_reset();
		chk(scan_test_mode, 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk(r[8:0], 9'h00e);
		$display("test second reset done");
	endtask
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{err_count, num_checks, n_rst, n_inv, n_ucap, n_uupd} = '0;
		core_data_in = 32'hcafe_0123;
		break_request_in = 1'b1;
		ext = 4'ha;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		host_inst.link_reset();
		t_idcode();
		t_bypass();
		t_user();
		t_chain1();
		t_cop();
		t_comms();
		t_reset();
		close_out(0);
	end
	initial begin
		repeat (90000) @(posedge clk);
		close_out(1);
	end
endmodule
